// File: logic/scale_serial_weight_framer.sv
`include "weight_framer_params.svh"

module char_fifo #(
    parameter int W = 7,
    parameter int D = 16
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [0:D-1];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    logic push;
    logic pop;

    // Full when the pointers differ only in the wrap bit.
    assign in_ready_out = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
    assign out_valid_out = (wr_r != rd_r);
    assign out_data_out = mem[rd_r[AW-1:0]];
    assign push = ce_in && in_valid_in && in_ready_out;
    assign pop = ce_in && out_valid_out && out_ready_in;

    // Storage array, written only on an accepted push.
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= in_data_in;
        end
    end

    // Pointers advance on accepted transfers.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule

module scale_serial_weight_framer
    import weight_framer_pkg::*;
#(
    parameter int unsigned BIT_CYC_LO = `CLK_HZ / `BAUD_LO,
    parameter int unsigned BIT_CYC_MID = `CLK_HZ / `BAUD_MID,
    parameter int unsigned BIT_CYC_HI = `CLK_HZ / `BAUD_HI,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic CE_IN,
    input wire logic [1:0] PRINT_FORMAT_SELECT_IN,
    input wire logic CHECKSUM_ENABLE_STEP_IN,
    input wire logic EXPAND_PRINT_IN,
    input wire logic [1:0] BAUD_SEL_IN,
    input wire logic [2:0] WEIGH_MODE_IN,
    input wire logic [2:0] DP_CODE_IN,
    input wire logic [1:0] INCR_SIZE_IN,
    input wire logic NET_MODE_IN,
    input wire logic TARE_VALID_IN,
    input wire logic NEGATIVE_IN,
    input wire logic OVERCAP_IN,
    input wire logic MOTION_IN,
    input wire logic EXPANDED_MODE_IN,
    input wire logic MANUAL_TARE_IN,
    input wire logic [23:0] GROSS_BCD_IN,
    input wire logic [23:0] TARE_BCD_IN,
    input wire logic [23:0] NET_BCD_IN,
    input wire logic [23:0] DISP_BCD_IN,
    input wire logic PRINT_REQ_IN,
    input wire logic ADC_UPDATE_IN,
    input wire logic IS_OVER_IN,
    input wire logic IS_ACCEPT_IN,
    input wire logic IS_UNDER_IN,
    input wire logic TARGET_N_IN,
    output logic TXD_OUT,
    output logic BUSY_OUT,
    output logic TARGET_PULSE_OUT,
    output logic OVER_N_OUT,
    output logic ACCEPT_N_OUT,
    output logic UNDER_N_OUT
);
    seq_state_t state_r;
    line_kind_t kind_r;
    line_kind_t kind_sel;
    line_t line_r;
    line_t bld;
    logic [4:0] idx_r;
    logic print_pend_r;
    logic cont_pend_r;
    logic powerup_r;
    logic load;
    logic multi;
    logic cont_ok;
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_push;
    logic [6:0] fifo_data;
    logic tx_busy_r;
    logic [9:0] tx_sh_r;
    logic [3:0] tx_bit_r;
    logic [12:0] tx_cnt_r;
    logic [12:0] bit_cyc;
    logic [2:0] tgt_s_r;
    logic tgt_lvl_r;
    logic [6:0] stat_a;
    logic [6:0] stat_b;
    logic [6:0] stat_c;

    // Append one character and keep the running sum for the checksum.
    function automatic line_t push(line_t l, logic [6:0] c);
        line_t r;
        r = l;
        r.chars[l.len] = c;
        r.len = l.len + 5'h01;
        r.sum = l.sum + c;
        return r;
    endfunction

    // Sign, then six digits with leading zeros blanked and optional point.
    function automatic line_t put_dec(line_t l, logic [23:0] d, logic neg, logic [2:0] dp);
        line_t r;
        int dec;
        logic lead;
        r = push(l, neg ? `CH_MINUS : `CH_SP);
        dec = (dp > 3'h2) ? int'(dp) - 2 : 0;
        lead = 1'b1;
        for (int i = 5; i >= 0; i--) begin
            if (dec != 0 && i == dec - 1) begin
                r = push(r, `CH_DOT);
            end
            if (lead && d[i*4 +: 4] == 4'h0 && i > dec) begin
                r = push(r, `CH_SP);
            end else begin
                lead = 1'b0;
                r = push(r, `CH_ZERO + {3'h0, d[i*4 +: 4]});
            end
        end
        return r;
    endfunction

    // Pounds in the top two digits, ounces as two digits, point, two digits.
    function automatic line_t put_lboz(line_t l, logic [23:0] d, logic neg);
        line_t r;
        r = push(l, neg ? `CH_MINUS : `CH_SP);
        r = push(r, d[23:20] == 4'h0 ? `CH_SP : `CH_ZERO + {3'h0, d[23:20]});
        r = push(r, `CH_ZERO + {3'h0, d[19:16]});
        r = push(push(push(push(r, `CH_SP), `CH_L), `CH_B), `CH_SP);
        r = push(r, d[15:12] == 4'h0 ? `CH_SP : `CH_ZERO + {3'h0, d[15:12]});
        r = push(push(r, `CH_ZERO + {3'h0, d[11:8]}), `CH_DOT);
        r = push(push(r, `CH_ZERO + {3'h0, d[7:4]}), `CH_ZERO + {3'h0, d[3:0]});
        r = push(push(push(r, `CH_SP), `CH_O), `CH_Z);
        return r;
    endfunction

    // Status bytes; bit 7 is the frame parity bit added at transmission.
    assign stat_a = {2'b11, INCR_SIZE_IN[1] ? 2'b11 : INCR_SIZE_IN + 2'h1,
                     DP_CODE_IN};
    assign stat_b = {powerup_r, 1'b1, WEIGH_MODE_IN == WM_KG, MOTION_IN, OVERCAP_IN,
                     NEGATIVE_IN, NET_MODE_IN};
    assign stat_c = {MANUAL_TARE_IN, 1'b1, EXPANDED_MODE_IN, print_pend_r, WEIGH_MODE_IN};

    // A multiline print needs the format, a shown net weight and a tare.
    assign multi = PRINT_FORMAT_SELECT_IN == `FMT_MULTI && NET_MODE_IN && TARE_VALID_IN;
    assign cont_ok = WEIGH_MODE_IN == WM_LB || WEIGH_MODE_IN == WM_KG;

    // Pick the next line: prints before packets, then walk gross, tare, net.
    always_comb begin
        kind_sel = LK_CONT;
        if (state_r == SEQ_NEXT) begin
            kind_sel = (kind_r == LK_GROSS) ? LK_TARE : LK_NET;
        end else if (print_pend_r) begin
            kind_sel = multi ? LK_GROSS : LK_SINGLE;
        end
    end

    // Assemble the whole line in one step so sending never waits on formatting.
    always_comb begin
        logic [23:0] d;
        logic neg;
        logic lboz;
        bld = '0;
        d = GROSS_BCD_IN;
        neg = NEGATIVE_IN;
        lboz = WEIGH_MODE_IN == WM_LBOZ;
        if (kind_sel == LK_CONT) begin
            bld = push(push(push(push(bld, `CH_STX), stat_a), stat_b), stat_c);
            for (int i = 5; i >= 0; i--) begin
                bld = push(bld, `CH_ZERO + {3'h0, DISP_BCD_IN[i*4 +: 4]});
            end
            for (int i = 5; i >= 0; i--) begin
                bld = push(bld, `CH_ZERO + {3'h0, TARE_BCD_IN[i*4 +: 4]});
            end
            bld = push(bld, `CH_CR);
        end else begin
            if (kind_sel == LK_TARE) begin
                d = TARE_BCD_IN;
                neg = 1'b0;
            end else if (kind_sel == LK_NET) begin
                d = NET_BCD_IN;
            end
            if (kind_sel == LK_GROSS || kind_sel == LK_SINGLE) begin
                bld = push(bld, `CH_STX);
            end
            if (kind_sel == LK_NET || (kind_sel == LK_SINGLE && EXPAND_PRINT_IN)) begin
                bld = push(bld, `CH_SO);
            end
            if (lboz) begin
                bld = put_lboz(bld, d, neg);
            end else begin
                bld = push(put_dec(bld, d, neg, DP_CODE_IN), `CH_SP);
                case (WEIGH_MODE_IN)
                    WM_KG: bld = push(push(bld, `CH_K_LO), `CH_G_LO);
                    WM_OZ: bld = push(push(bld, `CH_O), `CH_Z);
                    WM_G: bld = push(bld, `CH_G_LO);
                    default: bld = push(push(bld, `CH_L), `CH_B);
                endcase
            end
            if (kind_sel == LK_TARE) begin
                bld = push(push(push(bld, `CH_SP), `CH_T), `CH_R);
            end
            if (kind_sel == LK_NET) begin
                bld = push(push(push(push(bld, `CH_SP), `CH_N), `CH_E), `CH_T);
            end
            if (kind_sel == LK_NET || (kind_sel == LK_SINGLE && EXPAND_PRINT_IN)) begin
                bld = push(bld, `CH_SI);
            end
            bld = push(bld, `CH_CR);
        end
        if (CHECKSUM_ENABLE_STEP_IN) begin
            bld = push(bld, 7'(~bld.sum + 7'h01));
        end
        if (kind_sel != LK_CONT) begin
            bld = push(bld, `CH_LF);
        end
    end

    assign load = CE_IN && ((state_r == SEQ_IDLE && (print_pend_r || cont_pend_r)) ||
                  (state_r == SEQ_NEXT && (kind_r == LK_GROSS || kind_r == LK_TARE)));
    assign fifo_push = state_r == SEQ_SEND;

    // Pending requests; a new request in the taking cycle is kept.
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            print_pend_r <= 1'b0;
            cont_pend_r <= 1'b0;
        end else if (CE_IN) begin
            if (PRINT_REQ_IN) begin
                print_pend_r <= 1'b1;
            end else if (load && (kind_sel == LK_GROSS || kind_sel == LK_SINGLE)) begin
                print_pend_r <= 1'b0;
            end
            if (ADC_UPDATE_IN && cont_ok) begin
                cont_pend_r <= 1'b1;
            end else if (load && kind_sel == LK_CONT) begin
                cont_pend_r <= 1'b0;
            end
        end
    end

    // Power-up flag stands until the first packet has been formatted.
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            powerup_r <= 1'b1;
        end else if (load && kind_sel == LK_CONT) begin
            powerup_r <= 1'b0;
        end
    end

    // Line sequencer; a full buffer stalls it one character at a time.
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_r <= SEQ_IDLE;
            kind_r <= LK_CONT;
            line_r <= '0;
            idx_r <= 5'h00;
        end else if (CE_IN) begin
            case (state_r)
                SEQ_IDLE, SEQ_NEXT: begin
                    if (load) begin
                        kind_r <= kind_sel;
                        line_r <= bld;
                        idx_r <= 5'h00;
                        state_r <= SEQ_SEND;
                    end else begin
                        state_r <= SEQ_IDLE;
                    end
                end
                SEQ_SEND: begin
                    if (fifo_ready) begin
                        idx_r <= idx_r + 5'h01;
                        if (idx_r == line_r.len - 5'h01) begin
                            state_r <= SEQ_NEXT;
                        end
                    end
                end
                default: state_r <= SEQ_IDLE;
            endcase
        end
    end

    char_fifo #(.W(7), .D(FIFO_DEPTH)) u_fifo (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .ce_in(CE_IN),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_ready),
        .in_data_in(line_r.chars[idx_r]),
        .out_valid_out(fifo_valid),
        .out_ready_in(!tx_busy_r),
        .out_data_out(fifo_data)
    );

    // Any select outside the three rates falls back to the fastest one.
    assign bit_cyc = (BAUD_SEL_IN == `BAUD_SEL_LO) ? 13'(BIT_CYC_LO) :
                     (BAUD_SEL_IN == `BAUD_SEL_MID) ? 13'(BIT_CYC_MID) : 13'(BIT_CYC_HI);

    // Transmitter: start, seven data bits first bit lowest, even parity, stop.
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= 10'h3FF;
            tx_bit_r <= 4'h0;
            tx_cnt_r <= 13'h0000;
            TXD_OUT <= 1'b1;
        end else if (CE_IN) begin
            if (!tx_busy_r) begin
                if (fifo_valid) begin
                    tx_sh_r <= {1'b1, ^fifo_data, fifo_data, 1'b0};
                    tx_busy_r <= 1'b1;
                    tx_bit_r <= 4'h0;
                    tx_cnt_r <= 13'h0000;
                    TXD_OUT <= 1'b0;
                end
            end else if (tx_cnt_r >= bit_cyc - 13'h0001) begin
                tx_cnt_r <= 13'h0000;
                if (tx_bit_r == `FRAME_LAST_BIT) begin
                    tx_busy_r <= 1'b0;
                    TXD_OUT <= 1'b1;
                end else begin
                    tx_bit_r <= tx_bit_r + 4'h1;
                    TXD_OUT <= tx_sh_r[tx_bit_r + 4'h1];
                end
            end else begin
                tx_cnt_r <= tx_cnt_r + 13'h0001;
            end
        end
    end

    // Remote target pin: three stages, a fall counts once stages two and three agree low.
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            tgt_s_r <= 3'h7;
            tgt_lvl_r <= 1'b1;
            TARGET_PULSE_OUT <= 1'b0;
        end else if (CE_IN) begin
            tgt_s_r <= {tgt_s_r[1:0], TARGET_N_IN};
            if (tgt_s_r[1] == tgt_s_r[2]) begin
                tgt_lvl_r <= tgt_s_r[2];
            end
            TARGET_PULSE_OUT <= tgt_lvl_r && tgt_s_r[1] == tgt_s_r[2] && !tgt_s_r[2];
        end
    end

    // Indicator lamps sink when asserted, so drive low for the active class.
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            OVER_N_OUT <= 1'b1;
            ACCEPT_N_OUT <= 1'b1;
            UNDER_N_OUT <= 1'b1;
            BUSY_OUT <= 1'b0;
        end else if (CE_IN) begin
            OVER_N_OUT <= !IS_OVER_IN;
            ACCEPT_N_OUT <= !IS_ACCEPT_IN;
            UNDER_N_OUT <= !IS_UNDER_IN;
            BUSY_OUT <= state_r != SEQ_IDLE || fifo_valid || tx_busy_r;
        end
    end

    gross_then_tare_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        load && state_r == SEQ_NEXT && kind_r == LK_GROSS |=> kind_r == LK_TARE)
        else $error("tare line did not follow gross line");
    tare_then_net_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        load && state_r == SEQ_NEXT && kind_r == LK_TARE |=> kind_r == LK_NET)
        else $error("net line did not follow tare line");
    no_tare_single_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        load && state_r == SEQ_IDLE && print_pend_r && !TARE_VALID_IN |=> kind_r == LK_SINGLE)
        else $error("print without tare was not a single line");
    cont_units_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        CE_IN && ADC_UPDATE_IN && !cont_ok && !cont_pend_r |=> !cont_pend_r)
        else $error("packet queued for units other than lb or kg");
    packet_len_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        load && kind_sel == LK_CONT |=>
        line_r.len == ($past(CHECKSUM_ENABLE_STEP_IN) ? `CONT_LEN_CKS : `CONT_LEN_NOCKS))
        else $error("continuous packet length wrong");
    packet_head_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        load && kind_sel == LK_CONT |=> line_r.chars[0] == `CH_STX
        && line_r.chars[1][6:5] == 2'b11 && line_r.chars[3][5])
        else $error("packet head or fixed status bits wrong");
    cks_zero_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        load && kind_sel == LK_CONT && CHECKSUM_ENABLE_STEP_IN |=> line_r.sum == 7'h00)
        else $error("packet checksum does not cancel the sum");
    line_end_lf_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        load && kind_sel != LK_CONT |=> line_r.chars[line_r.len - 5'h01] == `CH_LF)
        else $error("demand line does not end in line feed");
    start_bit_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        $rose(tx_busy_r) |-> !TXD_OUT && tx_sh_r[9] && (^tx_sh_r[8:1] == 1'b0))
        else $error("frame start, stop or even parity wrong");
    idle_high_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        $fell(tx_busy_r) |-> TXD_OUT && $past(TXD_OUT) && $past(TXD_OUT, 2))
        else $error("line not idle high after stop bit");
    lamp_follow_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        CE_IN |=> OVER_N_OUT == !$past(IS_OVER_IN) && UNDER_N_OUT == !$past(IS_UNDER_IN)
        && ACCEPT_N_OUT == !$past(IS_ACCEPT_IN))
        else $error("indicator output does not follow class");
endmodule

// File: logic/weight_framer_params.svh
`ifndef WEIGHT_FRAMER_PARAMS_SVH
`define WEIGHT_FRAMER_PARAMS_SVH

// System clock rate in hertz.
`define CLK_HZ 10000000
// The only three serial bit rates offered.
`define BAUD_LO 2400
`define BAUD_MID 4800
`define BAUD_HI 9600

// Baud select codes.
`define BAUD_SEL_LO 2'h0
`define BAUD_SEL_MID 2'h1

// Character codes, seven bits each.
`define CH_STX 7'h02
`define CH_LF 7'h0A
`define CH_CR 7'h0D
`define CH_SO 7'h0E
`define CH_SI 7'h0F
`define CH_SP 7'h20
`define CH_MINUS 7'h2D
`define CH_DOT 7'h2E
`define CH_ZERO 7'h30
`define CH_B 7'h42
`define CH_E 7'h45
`define CH_L 7'h4C
`define CH_N 7'h4E
`define CH_O 7'h4F
`define CH_R 7'h52
`define CH_T 7'h54
`define CH_Z 7'h5A
`define CH_G_LO 7'h67
`define CH_K_LO 7'h6B

// Multiline gross, tare, net choice of the print format select.
`define FMT_MULTI 2'h2

// Continuous packet lengths without and with the checksum byte.
`define CONT_LEN_NOCKS 5'h11
`define CONT_LEN_CKS 5'h12

// Bits of a serial frame: start, seven data, parity, stop.
`define FRAME_LAST_BIT 4'h9

`endif

// File: logic/weight_framer_pkg.sv
package weight_framer_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_SEND = 3'b010,
        SEQ_NEXT = 3'b100
    } seq_state_t;

    // Kind of line being built, one-hot.
    typedef enum logic [4:0] {
        LK_GROSS = 5'b00001,
        LK_TARE = 5'b00010,
        LK_NET = 5'b00100,
        LK_SINGLE = 5'b01000,
        LK_CONT = 5'b10000
    } line_kind_t;

    // Weigh mode codes as carried in status byte C bits 2..0.
    typedef enum logic [2:0] {
        WM_LB = 3'b000,
        WM_KG = 3'b001,
        WM_LBOZ = 3'b010,
        WM_OZ = 3'b011,
        WM_G = 3'b100
    } weigh_mode_t;

    // One assembled line: characters, count and running seven-bit sum.
    typedef struct packed {
        logic [23:0][6:0] chars;
        logic [4:0] len;
        logic [6:0] sum;
    } line_t;

endpackage

// File: bench/serial_rx_model.sv
// Printer side of the serial port: samples each frame in mid-bit.
module serial_rx_model (
    input wire logic clk_in,
    input wire logic rxd_in,
    input wire logic [15:0] bit_cyc_in,
    output logic [6:0] char_out,
    output logic got_out,
    output logic parity_err_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] frame;
    // The bit period is set by the bench to match the selected rate.
    always begin
        got_out = 1'b0;
        @(negedge rxd_in);
        repeat (bit_cyc_in / 2) @(posedge clk_in);
        frame[0] = rxd_in;
        for (int i = 1; i < 10; i++) begin
            repeat (bit_cyc_in) @(posedge clk_in);
            frame[i] = rxd_in;
        end
        char_out = frame[7:1];
        // Bad start, bad stop or odd parity all count as a framing fault.
        parity_err_out = (frame[8] != ^frame[7:1]) || frame[0] || !frame[9];
        got_out = 1'b1;
        @(posedge clk_in);
    end
endmodule

// File: bench/scale_serial_weight_framer_bench.sv
module scale_serial_weight_framer_bench;
    timeunit 1ns;
    timeprecision 1ns;
`include "weight_framer_params.svh"
    logic CLK_IN = 1'b0;
    logic NRST_IN, CE_IN, CHECKSUM_ENABLE_STEP_IN, EXPAND_PRINT_IN, NET_MODE_IN, TARE_VALID_IN;
    logic NEGATIVE_IN, OVERCAP_IN, MOTION_IN, EXPANDED_MODE_IN, MANUAL_TARE_IN, PRINT_REQ_IN;
    logic ADC_UPDATE_IN, IS_OVER_IN, IS_ACCEPT_IN, IS_UNDER_IN, TARGET_N_IN;
    logic [1:0] PRINT_FORMAT_SELECT_IN, BAUD_SEL_IN, INCR_SIZE_IN;
    logic [2:0] WEIGH_MODE_IN, DP_CODE_IN;
    logic [23:0] GROSS_BCD_IN, TARE_BCD_IN, NET_BCD_IN, DISP_BCD_IN;
    logic TXD_OUT, BUSY_OUT, TARGET_PULSE_OUT, OVER_N_OUT, ACCEPT_N_OUT, UNDER_N_OUT;
    logic [15:0] bit_cyc;
    logic [6:0] rx_char;
    logic rx_got, rx_perr;
    logic [6:0] rq[$];
    logic [6:0] ln[0:23];
    int n_errors = 0;
    int checked = 0;
    int pulses;

    // Short bit periods keep each frame to 80 to 160 clocks.
    scale_serial_weight_framer #(.BIT_CYC_LO(16), .BIT_CYC_MID(12), .BIT_CYC_HI(8)) u_dut (
        .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN),
        .PRINT_FORMAT_SELECT_IN(PRINT_FORMAT_SELECT_IN),
        .CHECKSUM_ENABLE_STEP_IN(CHECKSUM_ENABLE_STEP_IN), .EXPAND_PRINT_IN(EXPAND_PRINT_IN),
        .BAUD_SEL_IN(BAUD_SEL_IN), .WEIGH_MODE_IN(WEIGH_MODE_IN), .DP_CODE_IN(DP_CODE_IN),
        .INCR_SIZE_IN(INCR_SIZE_IN), .NET_MODE_IN(NET_MODE_IN), .TARE_VALID_IN(TARE_VALID_IN),
        .NEGATIVE_IN(NEGATIVE_IN), .OVERCAP_IN(OVERCAP_IN), .MOTION_IN(MOTION_IN),
        .EXPANDED_MODE_IN(EXPANDED_MODE_IN), .MANUAL_TARE_IN(MANUAL_TARE_IN),
        .GROSS_BCD_IN(GROSS_BCD_IN), .TARE_BCD_IN(TARE_BCD_IN), .NET_BCD_IN(NET_BCD_IN),
        .DISP_BCD_IN(DISP_BCD_IN), .PRINT_REQ_IN(PRINT_REQ_IN), .ADC_UPDATE_IN(ADC_UPDATE_IN),
        .IS_OVER_IN(IS_OVER_IN), .IS_ACCEPT_IN(IS_ACCEPT_IN), .IS_UNDER_IN(IS_UNDER_IN),
        .TARGET_N_IN(TARGET_N_IN), .TXD_OUT(TXD_OUT), .BUSY_OUT(BUSY_OUT),
        .TARGET_PULSE_OUT(TARGET_PULSE_OUT), .OVER_N_OUT(OVER_N_OUT),
        .ACCEPT_N_OUT(ACCEPT_N_OUT), .UNDER_N_OUT(UNDER_N_OUT));

    serial_rx_model u_rx (.clk_in(CLK_IN), .rxd_in(TXD_OUT), .bit_cyc_in(bit_cyc),
        .char_out(rx_char), .got_out(rx_got), .parity_err_out(rx_perr));

    // The clock toggles every half period of 100 ns.
    always #50 CLK_IN = ~CLK_IN;

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic ce(input int i, input logic [6:0] e);
        chk({1'b0, ln[i]}, {1'b0, e});
    endtask

    // Characters are collected at the falling edge, when the model's pulse is settled.
    always @(negedge CLK_IN) begin
        if (rx_got === 1'b1) begin
            rq.push_back(rx_char);
            chk({7'h00, rx_perr}, 8'h00);
        end
    end

    // A missing character reads as 7F so that any compare against it fails.
    task automatic rd(input int n);
        for (int i = 0; i < n; i++) begin
            for (int t = 0; t < 400 && rq.size() == 0; t++) @(posedge CLK_IN);
            ln[i] = (rq.size() == 0) ? 7'h7F : rq.pop_front();
        end
    endtask

    // Sum of a line up to and including its checksum is zero modulo 128.
    task automatic cks_ok(input int n);
        logic [6:0] s;
        s = 7'h00;
        for (int i = 0; i < n; i++) s = s + ln[i];
        chk({1'b0, s}, 8'h00);
    endtask

    task automatic req(input bit p);
        if (p) PRINT_REQ_IN <= 1'b1;
        else ADC_UPDATE_IN <= 1'b1;
        @(posedge CLK_IN);
        PRINT_REQ_IN <= 1'b0;
        ADC_UPDATE_IN <= 1'b0;
    endtask

    // Nothing may follow the expected characters once the block goes idle.
    task automatic idle_empty();
        for (int t = 0; t < 300 && BUSY_OUT !== 1'b0; t++) @(posedge CLK_IN);
        repeat (40) @(posedge CLK_IN);
        chk({BUSY_OUT, 7'(rq.size())}, 8'h00);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Main sequence: packets, a refused update, demand prints, lamps and target pin.
    initial begin
        bit_cyc = 16'h0008;
        {NRST_IN, PRINT_REQ_IN, ADC_UPDATE_IN, EXPAND_PRINT_IN, PRINT_FORMAT_SELECT_IN} <= '0;
        {NET_MODE_IN, TARE_VALID_IN, NEGATIVE_IN, OVERCAP_IN, EXPANDED_MODE_IN} <= '0;
        {MANUAL_TARE_IN, IS_OVER_IN, IS_ACCEPT_IN, IS_UNDER_IN, INCR_SIZE_IN} <= '0;
        {CE_IN, CHECKSUM_ENABLE_STEP_IN, MOTION_IN, TARGET_N_IN} <= 4'hF;
        BAUD_SEL_IN <= 2'h2;
        WEIGH_MODE_IN <= 3'h1;
        DP_CODE_IN <= 3'h2;
        DISP_BCD_IN <= 24'h012345;
        TARE_BCD_IN <= 24'h000100;
        GROSS_BCD_IN <= 24'h001250;
        NET_BCD_IN <= 24'h001150;
        repeat (3) @(posedge CLK_IN);
        NRST_IN <= 1'b1;
        @(posedge CLK_IN);
        req(0);
        rd(18);
        ce(0, `CH_STX);
        ce(1, 7'h6A);
        ce(2, 7'h78);
        ce(3, 7'h21);
        for (int i = 0; i < 6; i++) ce(4 + i, {3'h3, DISP_BCD_IN[23 - 4 * i -: 4]});
        for (int i = 0; i < 6; i++) ce(10 + i, {3'h3, TARE_BCD_IN[23 - 4 * i -: 4]});
        ce(16, `CH_CR);
        cks_ok(18);
        idle_empty();
        {CHECKSUM_ENABLE_STEP_IN, MOTION_IN, WEIGH_MODE_IN, BAUD_SEL_IN} <= 7'h00;
        {DP_CODE_IN, INCR_SIZE_IN} <= 5'h11;
        {NEGATIVE_IN, NET_MODE_IN, EXPANDED_MODE_IN, MANUAL_TARE_IN} <= 4'hF;
        bit_cyc = 16'h0010;
        @(posedge CLK_IN);
        req(0);
        rd(17);
        ce(1, 7'h74);
        ce(2, 7'h23);
        ce(3, 7'h70);
        ce(16, `CH_CR);
        idle_empty();
        WEIGH_MODE_IN <= 3'h3;
        @(posedge CLK_IN);
        req(0);
        idle_empty();
        {WEIGH_MODE_IN, BAUD_SEL_IN, DP_CODE_IN} <= 8'h2A;
        {CHECKSUM_ENABLE_STEP_IN, TARE_VALID_IN, NEGATIVE_IN, PRINT_FORMAT_SELECT_IN} <= 5'h1A;
        bit_cyc = 16'h000C;
        @(posedge CLK_IN);
        req(1);
        rd(14);
        ce(0, `CH_STX);
        ce(1, `CH_SP);
        ce(4, 7'h31);
        ce(9, `CH_K_LO);
        ce(11, `CH_CR);
        ce(13, `CH_LF);
        cks_ok(13);
        rd(16);
        ce(4, 7'h31);
        ce(11, `CH_T);
        ce(12, `CH_R);
        ce(15, `CH_LF);
        cks_ok(15);
        rd(19);
        ce(0, `CH_SO);
        ce(14, `CH_T);
        ce(15, `CH_SI);
        ce(18, `CH_LF);
        cks_ok(18);
        idle_empty();
        {TARE_VALID_IN, EXPAND_PRINT_IN} <= 2'h1;
        @(posedge CLK_IN);
        req(1);
        rd(16);
        ce(0, `CH_STX);
        ce(1, `CH_SO);
        ce(12, `CH_SI);
        ce(15, `CH_LF);
        cks_ok(15);
        // With the clock enable low the lamps and the pin filter must hold still.
        {CE_IN, IS_OVER_IN, IS_ACCEPT_IN, IS_UNDER_IN, TARGET_N_IN} <= 5'h08;
        repeat (3) @(posedge CLK_IN);
        chk({5'h00, OVER_N_OUT, ACCEPT_N_OUT, UNDER_N_OUT}, 8'h07);
        CE_IN <= 1'b1;
        pulses = 0;
        for (int t = 0; t < 12; t++) begin
            @(posedge CLK_IN);
            #1 pulses += (TARGET_PULSE_OUT === 1'b1);
        end
        chk({5'h00, OVER_N_OUT, ACCEPT_N_OUT, UNDER_N_OUT}, 8'h03);
        chk(8'(pulses), 8'h01);
        final_report();
    end

    // A hang counts as a mismatch and ends the run the normal way.
    initial begin
        repeat (30000) @(posedge CLK_IN);
        n_errors++;
        final_report();
    end
endmodule
